/* File: core/pcs_phase_gen.sv */
// pcs_phase_gen: splits the system clock into four one-hot phases
// assumes rst is synchronous to clk
`timescale 1ns/1ps
module pcs_phase_gen (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // phase strobes
  pcs_phase_if.gen  ph
);
  logic [pcs_pkg::PH_W-1:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= pcs_pkg::PH_ZERO;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < pcs_pkg::PHASES; g++) begin : g_ph
      assign ph.phase_oh[g] = !rst && (cnt_ff == pcs_pkg::PH_W'(g));
    end
  endgenerate

  assign ph.cycle_end = !rst && (cnt_ff == pcs_pkg::PH_LAST);
endmodule // pcs_phase_gen

/* File: core/pcs_phase_if.sv */
// pcs_phase_if: phase strobes between divider and sequencer
// assumes both sides run on the same clock
`timescale 1ns/1ps
interface pcs_phase_if;
  logic [3:0] phase_oh;
  logic       cycle_end;
  modport gen (output phase_oh, output cycle_end);
  modport use_ (input phase_oh, input cycle_end);
endinterface

/* File: core/pcs_pkg.sv */
// pcs_pkg: constants for the instruction sequencer
// assumes one 40 MHz clock and a synchronous active-high reset
package pcs_pkg;
  localparam int unsigned PC_W       = 13;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned PHASES     = 4;
  localparam int unsigned PH_W       = 2;
  localparam logic [PH_W-1:0] PH_LAST = 2'h3;
  localparam logic [PH_W-1:0] PH_ZERO = 2'h0;
  localparam logic [ADDR_W-1:0] PCL_ADDR = 8'h06;
  localparam logic [PC_W-1:0] VEC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] VEC_EXT   = 13'h0004;
  localparam logic [PC_W-1:0] VEC_TIMER_ZERO_OVERFLOW_SOURCE  = 13'h0008;
  localparam logic [PC_W-1:0] VEC_TIMER_ONE_OVERFLOW_SOURCE  = 13'h000c;
  localparam int unsigned LOW_W      = 8;
  localparam int unsigned PAGE_LSB   = 8;
  localparam int unsigned PAGE_W     = 5;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [PC_W-1:0] PC_TWO = 13'h0002;
  typedef enum logic [2:0] {
    PCS_XFER_NONE,
    PCS_XFER_JUMP,
    PCS_XFER_RET,
    PCS_XFER_SKIP,
    PCS_XFER_EXT,
    PCS_XFER_TIMER_ZERO_OVERFLOW_SOURCE,
    PCS_XFER_TIMER_ONE_OVERFLOW_SOURCE
  } pcs_xfer_e;
endpackage

/* File: core/pcs_sequencer.sv */
// pcs_sequencer: program counter and fetch/execute pipeline control
// assumes decoder, stack and interrupt logic share clk; requests are held
// by the core for the instruction cycle in which they are executed
//
// Operation
// - four non-overlapping phases form each instruction cycle of four clocks
// - fetch in one cycle, decode and execute in the next, overlapped
// - counter-changing instructions take two cycles with a dummy cycle
// - counter advances by one after every fetched word
// - taken skip discards prefetched word, dummy cycle, continues at counter plus one
// - counter is 13 bits wide, bits 12 down to 0
// - counter loads on jump, skip, low-byte write, call, return, reset, interrupts
// - low-byte register at 06h is read/write, reads low counter byte
// - low-byte write keeps page bits 12..8, replaces bits 7..0
// - vectors: reset 000h, external 004h, timer zero 008h, timer one 00ch
// - jump and call load all 13 bits from the instruction word
// - returns restore the counter from the stack value
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module pcs_sequencer (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // register port
  input  wire logic [pcs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pcs_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [pcs_pkg::DATA_W-1:0] reg_rdata,
  // transfer requests from decoder, stack and interrupt logic
  input  wire logic                      jump_req,
  input  wire logic [pcs_pkg::PC_W-1:0]   jump_target,
  input  wire logic                      ret_req,
  input  wire logic [pcs_pkg::PC_W-1:0]   stack_top,
  input  wire logic                      skip_req,
  input  wire logic                      ext_irq_ack,
  input  wire logic                      timer_zero_overflow_source,
  input  wire logic                      timer_one_overflow_source,
  // program memory
  output logic      [pcs_pkg::PC_W-1:0]   fetch_addr,
  output logic                           fetch_strobe,
  input  wire logic [15:0]               fetch_word,
  // execute stage
  output logic      [15:0]               exec_word,
  output logic                           exec_valid,
  output logic      [3:0]                phase,
  output logic                           cycle_end,
  output logic      [pcs_pkg::PC_W-1:0]   instruction_pointer
);
  pcs_phase_if ph_if ();

  pcs_phase_gen u_phase (
    .clk (clk),
    .rst (rst),
    .ph  (ph_if.gen)
  );

  logic [pcs_pkg::PC_W-1:0]   pc_ff;
  logic [pcs_pkg::PC_W-1:0]   nxt_pc;
  logic [15:0]               ir_ff;
  logic                      ir_valid_ff;
  logic [pcs_pkg::DATA_W-1:0] rdata_ff;
  logic                      pcl_wr_ff;
  logic [pcs_pkg::DATA_W-1:0] pcl_val_ff;
  logic                      fetch_ok;
  logic                      flush;
  pcs_pkg::pcs_xfer_e        xfer;

  function automatic logic hit_pcl(input logic [pcs_pkg::ADDR_W-1:0] a);
    hit_pcl = (a == pcs_pkg::PCL_ADDR);
  endfunction

  // low-byte write captured until cycle end
  always_ff @(posedge clk) begin
    if (rst) begin
      pcl_wr_ff  <= 1'b0;
      pcl_val_ff <= 8'h00;
    end else if (reg_wr && hit_pcl(reg_addr)) begin
      pcl_wr_ff  <= 1'b1;
      pcl_val_ff <= reg_wdata;
    end else if (ph_if.cycle_end) begin
      pcl_wr_ff  <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd && hit_pcl(reg_addr)) begin
      rdata_ff <= pc_ff[pcs_pkg::LOW_W-1:0];
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // transfer source, interrupts before executed transfers
  always_comb begin
    xfer = pcs_pkg::PCS_XFER_NONE;
    if (ext_irq_ack) begin
      xfer = pcs_pkg::PCS_XFER_EXT;
    end else if (timer_zero_overflow_source) begin
      xfer = pcs_pkg::PCS_XFER_TIMER_ZERO_OVERFLOW_SOURCE;
    end else if (timer_one_overflow_source) begin
      xfer = pcs_pkg::PCS_XFER_TIMER_ONE_OVERFLOW_SOURCE;
    end else if (ir_valid_ff && jump_req) begin
      xfer = pcs_pkg::PCS_XFER_JUMP;
    end else if (ir_valid_ff && ret_req) begin
      xfer = pcs_pkg::PCS_XFER_RET;
    end else if (ir_valid_ff && skip_req) begin
      xfer = pcs_pkg::PCS_XFER_SKIP;
    end
  end

  // any transfer flushes the prefetched word
  assign flush = (xfer != pcs_pkg::PCS_XFER_NONE) || pcl_wr_ff;

  always_comb begin
    nxt_pc = pc_ff;
    case (xfer)
      pcs_pkg::PCS_XFER_EXT:  nxt_pc = pcs_pkg::VEC_EXT;
      pcs_pkg::PCS_XFER_TIMER_ZERO_OVERFLOW_SOURCE: nxt_pc = pcs_pkg::VEC_TIMER_ZERO_OVERFLOW_SOURCE;
      pcs_pkg::PCS_XFER_TIMER_ONE_OVERFLOW_SOURCE: nxt_pc = pcs_pkg::VEC_TIMER_ONE_OVERFLOW_SOURCE;
      pcs_pkg::PCS_XFER_JUMP: nxt_pc = jump_target;
      pcs_pkg::PCS_XFER_RET:  nxt_pc = stack_top;
      // prefetched word was already counted, one more skips it
      pcs_pkg::PCS_XFER_SKIP: nxt_pc = pc_ff + pcs_pkg::PC_ONE;
      pcs_pkg::PCS_XFER_NONE: begin
        if (pcl_wr_ff) begin
          nxt_pc = {pc_ff[pcs_pkg::PC_W-1:pcs_pkg::PAGE_LSB], pcl_val_ff};
        end else begin
          nxt_pc = pc_ff + pcs_pkg::PC_ONE;
        end
      end
      default: nxt_pc = pc_ff;
    endcase
  end

  // 13-bit counter, loaded at cycle end
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_ff <= pcs_pkg::VEC_RESET;
    end else if (ph_if.cycle_end) begin
      pc_ff <= nxt_pc;
    end
  end

  assign fetch_ok = ph_if.cycle_end;

  // fetched word moves to execute stage
  always_ff @(posedge clk) begin
    if (rst) begin
      ir_ff       <= 16'h0000;
      ir_valid_ff <= 1'b0;
    end else if (fetch_ok) begin
      ir_ff <= fetch_word;
      ir_valid_ff <= !flush;
    end
  end

  assign fetch_addr          = pc_ff;
  assign fetch_strobe        = ph_if.phase_oh[0];
  assign exec_word           = ir_ff;
  assign exec_valid          = ir_valid_ff;
  assign phase               = ph_if.phase_oh;
  assign cycle_end           = ph_if.cycle_end;
  assign instruction_pointer = pc_ff;
  assign reg_rdata           = rdata_ff;
endmodule // pcs_sequencer

/* File: tb/pcs_assertions.sv */
// pcs_assertions: port checks for the sequencer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module pcs_assertions (
  input wire logic        clk, rst, reg_rd, reg_wr, jump_req, ret_req, skip_req, ext_irq_ack,
  input wire logic        timer_zero_overflow_source, timer_one_overflow_source,
  input wire logic        fetch_strobe, exec_valid, cycle_end,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata,
  input wire logic [12:0] jump_target, stack_top, fetch_addr, instruction_pointer,
  input wire logic [15:0] fetch_word, exec_word,
  input wire logic [3:0]  phase
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       wr_ff;
  logic [7:0] wd_ff;
  wire        irq = ext_irq_ack | timer_zero_overflow_source | timer_one_overflow_source;
  wire [12:0] vec = ext_irq_ack ? 13'h0004 : timer_zero_overflow_source ? 13'h0008 : 13'h000c;
  wire        xf = exec_valid & (jump_req | ret_req | skip_req);
  wire        quiet = cycle_end & !irq & !xf & !wr_ff & !reg_wr;
  wire [4:0]  pg = instruction_pointer[12:8];
  wire [7:0]  lo = instruction_pointer[7:0];
  // low-byte writes pending in this instruction cycle
  always_ff @(posedge clk) wr_ff <= !rst & ((wr_ff & !cycle_end) | (reg_wr & reg_addr == 8'h06));
  always_ff @(posedge clk) if (reg_wr && reg_addr == 8'h06) wd_ff <= reg_wdata;
  property p_cyc; cycle_end |=> !cycle_end [*3] ##1 cycle_end; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle length");
  property p_pipe; cycle_end |=> exec_word == $past(fetch_word); endproperty
  a_pipe: assert property (p_pipe) else $error("execute word");
  property p_inc; quiet |=> instruction_pointer == $past(instruction_pointer) + 13'h1 && exec_valid; endproperty
  a_inc: assert property (p_inc) else $error("increment");
  property p_jmp;
    cycle_end && exec_valid && jump_req && !irq |=> instruction_pointer == $past(jump_target) && !exec_valid ##4 exec_valid;
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump");
  property p_ret; cycle_end && xf && ret_req && !jump_req && !irq |=> instruction_pointer == $past(stack_top); endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_skip;
    cycle_end && xf && skip_req && !jump_req && !ret_req && !irq |=>
      instruction_pointer == $past(instruction_pointer) + 13'h1 && !exec_valid;
  endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_vec; cycle_end && irq |=> instruction_pointer == $past(vec) && !exec_valid; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_rd; reg_rd && reg_addr == 8'h06 |=> reg_rdata == $past(lo); endproperty
  a_rd: assert property (p_rd) else $error("low byte read");
  property p_low; cycle_end && wr_ff && !reg_wr && !irq && !xf |=> pg == $past(pg) && lo == $past(wd_ff); endproperty
  a_low: assert property (p_low) else $error("short jump");
  property p_rst; $fell(rst) |-> ##[0:1] phase == 4'h1 && fetch_strobe && fetch_addr == 13'h0 && !exec_valid; endproperty
  a_rst: assert property (p_rst) else $error("reset start");
  c_jmp: cover property (cycle_end && xf && jump_req);
  c_skip: cover property (cycle_end && xf && skip_req);
  c_low: cover property (cycle_end && wr_ff);
endmodule // pcs_assertions

/* File: tb/pcs_prog_mem.sv */
// pcs_prog_mem: program memory model
// assumes the word is taken by the sequencer at cycle end
`timescale 1ns/1ps
module pcs_prog_mem (
  // fetch side
  input  wire logic [12:0] fetch_addr,
  output logic      [15:0] fetch_word
);
  // each word carries its own address
  assign fetch_word = {3'h5, fetch_addr};
endmodule // pcs_prog_mem

/* File: tb/tb.sv */
// tb: self-checking bench for the sequencer
// assumes the sequencer and memory model share one clock
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, exec_valid, cycle_end;
  logic [7:0]  reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata, n = 8'h0;
  logic [5:0]  req = 6'h0;
  logic [12:0] jump_target = 13'h0, stack_top = 13'h0, fetch_addr, ip, pc_e = 13'h0, b, t;
  logic [15:0] fetch_word;
  logic [3:0]  phase;
  logic [12:0] pc_q[$];
  logic [7:0]  rd_q[$];
  int          n_fail = 0, n_tests = 0;
  pcs_sequencer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .jump_req(req[2]), .jump_target(jump_target), .ret_req(req[1]),
    .stack_top(stack_top), .skip_req(req[0]), .ext_irq_ack(req[5]), .timer_zero_overflow_source(req[4]),
    .timer_one_overflow_source(req[3]), .fetch_addr(fetch_addr), .fetch_strobe(), .fetch_word(fetch_word),
    .exec_word(), .exec_valid(exec_valid), .phase(phase), .cycle_end(cycle_end), .instruction_pointer(ip));
  pcs_prog_mem mem (.fetch_addr(fetch_addr), .fetch_word(fetch_word));
  initial forever #12.5 clk = ~clk;
  task automatic stop_test;
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_pc(input logic [12:0] g, e);
    n_tests++;
    if (g !== e) begin n_fail++; $display("ERROR %0t counter %h want %h", $time, g, e); end
  endtask
  task automatic chk_rd(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin n_fail++; $display("ERROR %0t read %h want %h", $time, g, e); end
  endtask
  // observer of read data and counter after each cycle end
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d && rd_q.size() > 0) chk_rd(reg_rdata, rd_q.pop_front());
    if (phase === 4'h1 && pc_q.size() > 0) chk_pc(ip, pc_q.pop_front());
  end
  task automatic al;
    do @(negedge clk); while (cycle_end !== 1'b1);
  endtask
  // one instruction cycle: request, read, optional write, expected counter
  task automatic op(input logic [5:0] r, input logic w, input logic [7:0] a, input logic [12:0] e);
    al;
    @(posedge clk);
    req <= r; reg_rd <= 1'b1; reg_addr <= a; reg_wdata <= n; jump_target <= t; stack_top <= ~t;
    rd_q.push_back(a == 8'h06 ? b[7:0] : 8'h00);
    @(posedge clk);
    reg_rd <= 1'b0; reg_wr <= w;
    @(posedge clk);
    reg_wr <= 1'b0;
    al;
    pc_q.push_back(e);
    @(posedge clk);
    req <= 6'h0;
    pc_e = e;
  endtask
  initial begin
    t = 13'($urandom(32'h354a));
    pc_q.push_back(13'h0);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      if (i == 9) begin
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        pc_q.push_back(13'h0);
        pc_e = 13'h0;
      end
      t = 13'($urandom);
      n = 8'($urandom);
      b = pc_e + 13'h1;
      case (i % 9)
        0: op(6'h00, 1'b0, 8'h06, b + 13'h1);
        1: op(6'h04, 1'b0, 8'h06, t);
        2: op(6'h02, 1'b0, 8'h06, ~t);
        3: op(6'h01, 1'b0, 8'h06, b + 13'h1);
        4: op(6'h00, 1'b1, 8'h06, {b[12:8], n});
        5: op(6'h00, 1'b1, 8'h07, b + 13'h1);
        6: op(6'h34, 1'b0, 8'h06, 13'h0004);
        7: op(6'h14, 1'b0, 8'h06, 13'h0008);
        default: op(6'h0c, 1'b0, 8'h06, 13'h000c);
      endcase
    end
    al;
    if (pc_q.size() + rd_q.size() != 0) begin
      n_fail++;
      $display("ERROR %0t results missing", $time);
    end
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test;
  end
endmodule // tb
bind pcs_sequencer pcs_assertions chk (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .jump_req(jump_req),
  .ret_req(ret_req), .skip_req(skip_req), .ext_irq_ack(ext_irq_ack),
  .timer_zero_overflow_source(timer_zero_overflow_source), .timer_one_overflow_source(timer_one_overflow_source),
  .fetch_strobe(fetch_strobe), .exec_valid(exec_valid), .cycle_end(cycle_end), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .jump_target(jump_target), .stack_top(stack_top),
  .fetch_addr(fetch_addr), .instruction_pointer(instruction_pointer), .fetch_word(fetch_word),
  .exec_word(exec_word), .phase(phase));
